// File: ussr_consts.vh
// constants for the universal serial shift register core
`ifndef USSR_CONSTS_VH
`define USSR_CONSTS_VH
// register indices and byte addresses (index times four)
`define USSR_IDX_CTL 8'h0D
`define USSR_IDX_STS 8'h0E
`define USSR_IDX_DAT 8'h0F
`define USSR_IDX_BUF 8'h10
`define USSR_ADR_CTL 8'h34
`define USSR_ADR_STS 8'h38
`define USSR_ADR_DAT 8'h3C
`define USSR_ADR_BUF 8'h40
// control fields
`define USSR_CTL_SIE 7
`define USSR_CTL_OIE 6
`define USSR_CTL_WM_HI 5
`define USSR_CTL_WM_LO 4
`define USSR_CTL_CS_HI 3
`define USSR_CTL_CS_LO 2
`define USSR_CTL_CLK 1
`define USSR_CTL_TOG 0
// status fields
`define USSR_STS_SIF 7
`define USSR_STS_OIF 6
`define USSR_STS_PF 5
`define USSR_STS_DC 4
// reset values and codes
`define USSR_RST_BYTE 8'h00
`define USSR_CNT_MAX 4'hF
`define USSR_WM_OFF 2'h0
`define USSR_WM_THREE 2'h1
`define USSR_WM_TWO 2'h2
`define USSR_WM_TWO_HOLD 2'h3
`define USSR_CS_SOFT 2'h0
`define USSR_CS_TIMER 2'h1
`define USSR_CS_EXT_POS 2'h2
`define USSR_CS_EXT_NEG 2'h3
`define USSR_HTRANS_NONSEQ 2'h2
`endif

// File: ussr_core.v
// register core of the universal serial interface with an ahb-lite slave
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "ussr_consts.vh"

module ussr_core
(
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  input wire data_in_pin,
  input wire serial_clock_pin,
  input wire timer0_match,
  input wire global_int_en,
  input wire sleep_idle,
  input wire data_dir,
  input wire clock_dir,
  output wire data_out,
  output wire data_out_oe,
  output wire sda_out,
  output wire sda_oe,
  output wire scl_out,
  output wire scl_oe,
  output wire start_irq,
  output wire overflow_irq,
  output wire wake_req
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  reg di_s1_ff;
  reg di_s2_ff;
  reg di_s3_ff;
  reg ck_s1_ff;
  reg ck_s2_ff;
  reg ck_s3_ff;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      di_s1_ff <= 1'h1;
      di_s2_ff <= 1'h1;
      di_s3_ff <= 1'h1;
      ck_s1_ff <= 1'h1;
      ck_s2_ff <= 1'h1;
      ck_s3_ff <= 1'h1;
    end
    else if (clk_en)
    begin
      di_s1_ff <= data_in_pin;
      di_s2_ff <= di_s1_ff;
      di_s3_ff <= di_s2_ff;
      ck_s1_ff <= serial_clock_pin;
      ck_s2_ff <= ck_s1_ff;
      ck_s3_ff <= ck_s2_ff;
    end
  end

  wire ck_rise = ck_s2_ff & ~ck_s3_ff;
  wire ck_fall = ~ck_s2_ff & ck_s3_ff;
  wire di_rise = di_s2_ff & ~di_s3_ff;
  wire di_fall = ~di_s2_ff & di_s3_ff;

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  reg hreadyout_ff;
  reg [31:0] hrdata_ff;
  reg hresp_ff;
  reg dph_wr_ff;
  reg dph_rd_ff;
  reg [7:0] dph_adr_ff;

  // state
  reg sie_ff;
  reg oie_ff;
  reg [1:0] wm_ff;
  reg [1:0] cs_ff;
  reg clk_mode_ff;
  reg sflag_ff;
  reg oflag_ff;
  reg pflag_ff;
  reg [3:0] cnt_ff;
  reg [7:0] sr_ff;
  reg [7:0] rbuf_ff;
  reg latch_ff;
  reg port_ck_ff;
  reg start_hold_ff;
  reg [7:0] nxt_rd;

  // slow read path kept off the address phase: one wait state
  // lets a read see a write that finishes in the same cycle
  wire take = hsel & hready & htrans[1];
  wire wr_act = dph_wr_ff & hreadyout_ff;
  wire wr_ctl = wr_act & (dph_adr_ff == `USSR_ADR_CTL);
  wire wr_sts = wr_act & (dph_adr_ff == `USSR_ADR_STS);
  wire wr_dat = wr_act & (dph_adr_ff == `USSR_ADR_DAT);
  wire [7:0] wb = hwdata[7:0];
  wire two_wire = wm_ff[1];
  wire collide = sr_ff[7] ^ di_s2_ff;

  always @*
  begin
    case (dph_adr_ff)
      `USSR_ADR_CTL: nxt_rd = {sie_ff, oie_ff, wm_ff, cs_ff, 2'h0};
      `USSR_ADR_STS: nxt_rd = {sflag_ff, oflag_ff, pflag_ff, collide, cnt_ff};
      `USSR_ADR_DAT: nxt_rd = sr_ff;
      `USSR_ADR_BUF: nxt_rd = rbuf_ff;
      default: nxt_rd = `USSR_RST_BYTE;
    endcase
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_ff <= 1'h1;
      hrdata_ff <= 32'h00000000;
      hresp_ff <= 1'h0;
      dph_wr_ff <= 1'h0;
      dph_rd_ff <= 1'h0;
      dph_adr_ff <= 8'h00;
    end
    else if (clk_en)
    begin
      if (dph_rd_ff)
      begin
        hrdata_ff <= {24'h000000, nxt_rd};
        hreadyout_ff <= 1'h1;
        dph_rd_ff <= 1'h0;
      end
      else if (hreadyout_ff)
      begin
        dph_wr_ff <= take & hwrite;
        dph_rd_ff <= take & ~hwrite;
        hreadyout_ff <= ~(take & ~hwrite);
        if (take)
        begin
          dph_adr_ff <= haddr[7:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // clock selection
  // ---------------------------------------------------------------
  wire sw_clk = wr_ctl & wb[`USSR_CTL_CLK];
  wire sw_tog = wr_ctl & wb[`USSR_CTL_TOG];
  reg shift_t;
  reg count_t;

  always @*
  begin
    shift_t = 1'h0;
    count_t = 1'h0;
    case (cs_ff)
      `USSR_CS_SOFT:
      begin
        shift_t = sw_clk;
        count_t = sw_clk | sw_tog;
      end
      `USSR_CS_TIMER:
      begin
        shift_t = timer0_match;
        count_t = timer0_match;
      end
      `USSR_CS_EXT_POS, `USSR_CS_EXT_NEG:
      begin
        if (clk_mode_ff)
        begin
          shift_t = sw_tog;
          count_t = sw_tog;
        end
        else
        begin
          // pins act in every wire mode, including off
          shift_t = cs_ff[0] ? ck_fall : ck_rise;
          count_t = ck_rise | ck_fall;
        end
      end
      default:
      begin
        shift_t = 1'h0;
        count_t = 1'h0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sie_ff <= 1'h0;
      oie_ff <= 1'h0;
      wm_ff <= `USSR_WM_OFF;
      cs_ff <= `USSR_CS_SOFT;
      clk_mode_ff <= 1'h0;
      port_ck_ff <= 1'h1;
    end
    else if (clk_en)
    begin
      if (wr_ctl)
      begin
        sie_ff <= wb[`USSR_CTL_SIE];
        oie_ff <= wb[`USSR_CTL_OIE];
        wm_ff <= wb[`USSR_CTL_WM_HI:`USSR_CTL_WM_LO];
        cs_ff <= wb[`USSR_CTL_CS_HI:`USSR_CTL_CS_LO];
        clk_mode_ff <= wb[`USSR_CTL_CLK];
      end
      if (sw_tog)
      begin
        port_ck_ff <= ~port_ck_ff;
      end
    end
  end

  // ---------------------------------------------------------------
  // shifter, counter, buffer
  // ---------------------------------------------------------------
  wire wrap = count_t & (cnt_ff == `USSR_CNT_MAX) & ~wr_sts;
  wire [7:0] shifted = {sr_ff[6:0], di_s2_ff};

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sr_ff <= `USSR_RST_BYTE;
      rbuf_ff <= `USSR_RST_BYTE;
      cnt_ff <= 4'h0;
    end
    else if (clk_en)
    begin
      if (wr_dat)
      begin
        sr_ff <= wb;
      end
      else if (shift_t)
      begin
        sr_ff <= shifted;
      end
      if (wr_sts)
      begin
        cnt_ff <= wb[3:0];
      end
      else if (count_t)
      begin
        cnt_ff <= cnt_ff + 4'h1;
      end
      if (wrap)
      begin
        rbuf_ff <= (shift_t & ~wr_dat) ? shifted : sr_ff;
      end
    end
  end

  // ---------------------------------------------------------------
  // flags and condition detection
  // ---------------------------------------------------------------
  wire start_cond = two_wire & di_fall & ck_s2_ff;
  wire stop_cond = two_wire & di_rise & ck_s2_ff;
  wire edge_start = ~two_wire & cs_ff[1] & ~clk_mode_ff & (ck_rise | ck_fall);
  wire clr_s = wr_sts & wb[`USSR_STS_SIF];
  wire clr_o = wr_sts & wb[`USSR_STS_OIF];
  wire clr_p = wr_sts & wb[`USSR_STS_PF];

  // start and stop: set wins over a clear in the same cycle; any status write blocks the overflow set
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sflag_ff <= 1'h0;
      oflag_ff <= 1'h0;
      pflag_ff <= 1'h0;
      start_hold_ff <= 1'h0;
    end
    else if (clk_en)
    begin
      if (start_cond | edge_start)
      begin
        sflag_ff <= 1'h1;
      end
      else if (clr_s)
      begin
        sflag_ff <= 1'h0;
      end
      if (wrap)
      begin
        oflag_ff <= 1'h1;
      end
      else if (clr_o)
      begin
        oflag_ff <= 1'h0;
      end
      if (stop_cond)
      begin
        pflag_ff <= 1'h1;
      end
      else if (clr_p)
      begin
        pflag_ff <= 1'h0;
      end
      // hold grabs the first clock fall after a start
      if (two_wire & sflag_ff & ck_fall)
      begin
        start_hold_ff <= 1'h1;
      end
      else if (~sflag_ff | ~two_wire)
      begin
        start_hold_ff <= 1'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // output latch and pins
  // ---------------------------------------------------------------
  // external source: latch follows bit 7 while the clock sits in the
  // phase opposite to the sampling edge, so data moves on the other edge
  wire ext_src = cs_ff[1];
  wire latch_open = ~ext_src | (cs_ff[0] ? ck_s2_ff : ~ck_s2_ff);
  wire ovf_hold = (wm_ff == `USSR_WM_TWO_HOLD) & oflag_ff;
  wire scl_low = ~port_ck_ff | start_hold_ff | ovf_hold;

  reg data_out_ff;
  reg data_out_oe_ff;
  reg sda_oe_ff;
  reg scl_out_ff;
  reg scl_oe_ff;
  reg start_irq_ff;
  reg overflow_irq_ff;
  reg wake_ff;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      latch_ff <= 1'h0;
      data_out_ff <= 1'h0;
      data_out_oe_ff <= 1'h0;
      sda_oe_ff <= 1'h0;
      scl_out_ff <= 1'h1;
      scl_oe_ff <= 1'h0;
      start_irq_ff <= 1'h0;
      overflow_irq_ff <= 1'h0;
      wake_ff <= 1'h0;
    end
    else if (clk_en)
    begin
      if (latch_open)
      begin
        latch_ff <= wr_dat ? wb[7] : sr_ff[7];
      end
      data_out_ff <= latch_ff;
      data_out_oe_ff <= data_dir & (wm_ff == `USSR_WM_THREE);
      sda_oe_ff <= data_dir & two_wire & ~latch_ff;
      if (two_wire)
      begin
        scl_out_ff <= 1'h0;
        scl_oe_ff <= clock_dir & scl_low;
      end
      else
      begin
        scl_out_ff <= port_ck_ff;
        scl_oe_ff <= clock_dir & (wm_ff == `USSR_WM_THREE);
      end
      start_irq_ff <= sflag_ff & sie_ff & global_int_en;
      overflow_irq_ff <= oflag_ff & oie_ff & global_int_en;
      // stop flag never reaches an interrupt or wake
      wake_ff <= (sflag_ff & sie_ff) | (oflag_ff & oie_ff & sleep_idle);
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign hrdata = hrdata_ff;
  assign data_out = data_out_ff;
  assign data_out_oe = data_out_oe_ff;
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_ff;
  assign scl_out = scl_out_ff;
  assign scl_oe = scl_oe_ff;
  assign start_irq = start_irq_ff;
  assign overflow_irq = overflow_irq_ff;
  assign wake_req = wake_ff;

endmodule // ussr_core

// File: ussr_props.sv
// assertion checker for the serial shift register core
`timescale 1ns/1ps
module ussr_props (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic hready,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic hreadyout,
  input logic hresp,
  input logic [31:0] hrdata,
  input logic data_dir,
  input logic data_out_oe,
  input logic sda_out,
  input logic global_int_en,
  input logic sleep_idle,
  input logic start_irq,
  input logic overflow_irq,
  input logic wake_req
);
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // --------
  // properties
  // --------
  property p_rd;
    hsel && hready && htrans[1] && !hwrite && hreadyout |=> !hreadyout ##1 hreadyout;
  endproperty
  property p_wait;
    !hreadyout |=> hreadyout;
  endproperty
  property p_up;
    hreadyout |-> hrdata[31:8] == 24'h0 && !hresp;
  endproperty
  property p_oe;
    data_out_oe |-> $past(data_dir);
  endproperty
  property p_sirq;
    start_irq |-> $past(global_int_en);
  endproperty
  property p_oirq;
    $rose(overflow_irq) |-> $past(global_int_en);
  endproperty
  // overflow may only wake the core out of idle sleep
  property p_wake;
    $past(global_int_en) |-> wake_req == (start_irq || (overflow_irq && $past(sleep_idle)));
  endproperty
  property p_sda;
    !sda_out;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  a_wait: assert property (p_wait) else $error("wait state too long");
  a_up: assert property (p_up) else $error("upper read bits set");
  a_oe: assert property (p_oe) else $error("data out without direction");
  a_sirq: assert property (p_sirq) else $error("start irq ungated");
  a_oirq: assert property (p_oirq) else $error("overflow irq ungated");
  a_wake: assert property (p_wake) else $error("wake request wrong");
  a_sda: assert property (p_sda) else $error("data line driven high");
  c_ovf: cover property ($rose(overflow_irq));
  c_st: cover property ($rose(start_irq));
  c_rd: cover property ($fell(hreadyout));
endmodule // ussr_props

bind ussr_core ussr_props u_props (.*);

// File: ussr_peer.sv
// serial master model driving clock and data into the core
`timescale 1ns/1ps
module ussr_peer (
  input logic go,
  input logic [7:0] tx,
  input logic miso,
  output logic sck,
  output logic di,
  output logic [7:0] rx,
  output logic done
);
  initial
  begin
    sck = 1'b0;
    di = 1'b0;
    rx = 8'h00;
    done = 1'b0;
  end
  // clock stands low between frames; data set half a period before each rise
  always @(posedge go)
  begin
    done = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      di = tx[i];
      #24 sck = 1'b1;
      // output is latched while the clock is high, so sample late in that phase
      #24 rx = {rx[6:0], miso};
      sck = 1'b0;
    end
    #24 di = ~di;
    done = 1'b1;
  end
endmodule // ussr_peer

// File: tb.sv
// self-checking testbench for the serial shift register core
`timescale 1ns/1ps
`include "ussr_consts.vh"
module tb;
  logic hclk, hresetn, hsel, hwrite, timer0_match, sleep_idle, data_dir, go, global_int_en;
  localparam int k_oe = 0;
  localparam int k_si = 1;
  localparam int k_oi = 2;
  localparam int k_wk = 3;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [7:0] tx, r;
  wire [31:0] hrdata;
  wire [7:0] rx;
  wire hreadyout, hresp, data_in_pin, serial_clock_pin, data_out, data_out_oe, done;
  wire sda_out, sda_oe, scl_out, scl_oe, start_irq, overflow_irq, wake_req;
  wire hready = hreadyout;
  wire clk_en = 1'b1;
  // pin checks read this after settling, not a copy taken at call time
  wire [3:0] obs = {wake_req, overflow_irq, start_irq, data_out_oe};
  wire clock_dir = 1'b0;
  wire [2:0] hsize = 3'h2;
  int num_errors = 0;
  int total_checks = 0;
  ussr_core uut (.*);
  ussr_peer peer (.go(go), .tx(tx), .miso(data_out), .sck(serial_clock_pin),
    .di(data_in_pin), .rx(rx), .done(done));
  // --------
  // tasks
  // --------
  task automatic chk(input string s, input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
    input logic tm, output logic [7:0] q);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= `USSR_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    n = 0;
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    timer0_match <= tm;
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
    q = hrdata[7:0];
    timer0_match <= 1'b0;
    if (n >= 50)
      num_errors++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, 1'b0, q);
  endtask
  task automatic rd(input string s, input logic [7:0] a, input logic [7:0] m,
    input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, 1'b0, q);
    chk(s, q & m, e);
  endtask
  task automatic pin(input string s, input int k, input logic e);
    repeat (3) @(posedge hclk);
    chk(s, {7'h0, obs[k]}, {7'h0, e});
  endtask
  task automatic frame(input logic [7:0] t);
    int n;
    @(posedge hclk);
    tx <= t;
    go <= 1'b1;
    n = 0;
    do @(posedge hclk); while (done !== 1'b1 && ++n < 400);
    go <= 1'b0;
    if (n >= 400)
      num_errors++;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // run takes about 2 us; allow ten times that
  initial
  begin
    #20000;
    num_errors++;
    summarize();
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    timer0_match = 1'b0;
    sleep_idle = 1'b0;
    global_int_en = 1'b1;
    data_dir = 1'b0;
    go = 1'b0;
    tx = 8'h00;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd("ctl", `USSR_ADR_CTL, 8'hFF, 8'h00);
    rd("sts", `USSR_ADR_STS, 8'hEF, 8'h00);
    rd("buf", `USSR_ADR_BUF, 8'hFF, 8'h00);
    rd("unmapped", 8'h00, 8'hFF, 8'h00);
    wr(`USSR_ADR_CTL, 8'hFC);
    rd("ctl rw", `USSR_ADR_CTL, 8'hFF, 8'hFC);
    $display("register test done");
    wr(`USSR_ADR_CTL, 8'h00);
    wr(`USSR_ADR_STS, 8'h0E);
    wr(`USSR_ADR_DAT, 8'h81);
    wr(`USSR_ADR_CTL, 8'h02);
    wr(`USSR_ADR_CTL, 8'h02);
    rd("strobes", `USSR_ADR_CTL, 8'hFF, 8'h00);
    rd("wrap", `USSR_ADR_STS, 8'hEF, 8'h40);
    rd("dat", `USSR_ADR_DAT, 8'hFF, 8'h04);
    rd("buf", `USSR_ADR_BUF, 8'hFF, 8'h04);
    pin("ovf masked", k_oi, 1'b0);
    wr(`USSR_ADR_CTL, 8'h40);
    pin("ovf irq", k_oi, 1'b1);
    pin("wake busy", k_wk, 1'b0);
    sleep_idle <= 1'b1;
    pin("wake idle", k_wk, 1'b1);
    wr(`USSR_ADR_STS, 8'h40);
    pin("ovf clear", k_oi, 1'b0);
    $display("strobe test done");
    for (int m = 1; m >= 0; m--)
    begin
      wr(`USSR_ADR_CTL, {2'b00, m[1:0], 4'b1000});
      wr(`USSR_ADR_STS, 8'hE0);
      wr(`USSR_ADR_DAT, 8'hA5);
      data_dir <= 1'b1;
      frame(8'h3C);
      if (m == 1)
        chk("out byte", rx, 8'hA5);
      pin("out enable", k_oe, m[0]);
      rd("edge sts", `USSR_ADR_STS, 8'hEF, 8'hC0);
      rd("rx dat", `USSR_ADR_DAT, 8'hFF, 8'h3C);
      rd("rx buf", `USSR_ADR_BUF, 8'hFF, 8'h3C);
    end
    global_int_en <= 1'b0;
    wr(`USSR_ADR_CTL, 8'h80);
    pin("start gated", k_si, 1'b0);
    global_int_en <= 1'b1;
    pin("start irq", k_si, 1'b1);
    pin("wake start", k_wk, 1'b1);
    wr(`USSR_ADR_STS, 8'h80);
    pin("start clear", k_si, 1'b0);
    $display("frame test done");
    wr(`USSR_ADR_CTL, 8'h04);
    bus(1'b1, `USSR_ADR_DAT, 8'h55, 1'b1, r);
    rd("write wins", `USSR_ADR_DAT, 8'hFF, 8'h55);
    @(posedge hclk);
    timer0_match <= 1'b1;
    @(posedge hclk);
    timer0_match <= 1'b0;
    rd("timer shift", `USSR_ADR_DAT, 8'hFF, 8'hAB);
    $display("timer test done");
    summarize();
  end
endmodule // tb
